// >>> core/pmsc_top.v
// Purpose: power management status and control registers
// Assumes: detector outputs are asynchronous; stop recovery arrives as pulses
// Notes: stop sequencing and analog thresholds are outside this block
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "pmsc_defines.vh"
module pmsc_top (
   input wire clk, // bus clock, 100 MHz
   input wire rst_n, // synchronous reset, active low
   input wire por_event, // high during/at a power-on reset
   input wire lv_reset_event, // high during/at a low-voltage reset
   input wire [`PMSC_ADDR_W-1:0] reg_addr, // register index
   input wire [7:0] reg_wdata, // write data
   input wire reg_wr, // write strobe
   input wire reg_rd, // read strobe
   output reg [7:0] reg_rdata, // read data, cycle after strobe
   input wire undervolt_detect_in, // async detector output
   input wire undervolt_warning_in, // async warning comparator output
   input wire stop_active, // high while the part is in stop mode
   input wire stop1_recovered, // one-cycle pulse, woke from stop1
   input wire stop2_recovered, // one-cycle pulse, woke from stop2
   output wire undervolt_irq, // interrupt request level
   output wire undervolt_reset_req, // full reset request level
   output wire detector_active, // analog detector power on
   output wire bandgap_buffer_on, // bandgap buffer enable
   output wire stop1_allowed, // stop1 entry permitted
   output wire stop2_allowed, // stop2 entry permitted
   output wire detect_trip_select, // high detect trip when 1
   output wire warning_trip_select // high warning trip when 1
);
   wire [1:0] sync_q;
   wire det_s;
   wire warn_s;
   wire wr_one;
   wire wr_two;
   wire wr_three;
   wire [1:0] once_val;
   wire undervolt_detector_on;
   wire undervolt_reset_enable;
   reg undervolt_detect_flag_reg;
   reg undervolt_detect_flag_next;
   reg undervolt_irq_enable_reg;
   reg undervolt_stop_enable_reg;
   reg bandgap_reg;
   reg full_powerdown_flag_reg;
   reg full_powerdown_flag_next;
   reg partial_powerdown_flag_reg;
   reg partial_powerdown_flag_next;
   reg powerdown_permit_reg;
   reg powerdown_mode_select_reg;
   reg undervolt_warning_flag_reg;
   reg undervolt_warning_flag_next;
   reg detect_trip_reg;
   reg warning_trip_reg;
   reg [7:0] rdata_next;

   function is_wr;
      input [`PMSC_ADDR_W-1:0] a;
      input [`PMSC_ADDR_W-1:0] target;
      input w;
      begin
         is_wr = w && (a == target);
      end
   endfunction

   pmsc_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in({undervolt_warning_in, undervolt_detect_in}),
      .sync_out(sync_q)
   );

   assign det_s = sync_q[0];
   assign warn_s = sync_q[1];
   assign wr_one = is_wr(reg_addr, `PMSC_OFS_ONE, reg_wr);
   assign wr_two = is_wr(reg_addr, `PMSC_OFS_TWO, reg_wr);
   assign wr_three = is_wr(reg_addr, `PMSC_OFS_THREE, reg_wr);

   // reset enable and detector on share one write-once lock
   pmsc_wonce #(
      .WIDTH(2),
      .RESET_VAL(2'b11)
   ) u_wonce (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(wr_one),
      .wr_data({reg_wdata[`PMSC_B_UV_RST_EN], reg_wdata[`PMSC_B_UV_DET_ON]}),
      .value(once_val),
      .locked()
   );
   assign undervolt_reset_enable = once_val[1];
   assign undervolt_detector_on = once_val[0];

   // detection runs unless disabled, or in stop without stop enable
   assign detector_active = undervolt_detector_on && (!stop_active || undervolt_stop_enable_reg);
   assign undervolt_irq = undervolt_detector_on && undervolt_irq_enable_reg && undervolt_detect_flag_reg;
   assign undervolt_reset_req = undervolt_detector_on && undervolt_reset_enable
      && undervolt_detect_flag_reg;
   assign bandgap_buffer_on = bandgap_reg;
   assign stop1_allowed = powerdown_permit_reg && !powerdown_mode_select_reg;
   assign stop2_allowed = powerdown_permit_reg && powerdown_mode_select_reg;
   assign detect_trip_select = detect_trip_reg;
   assign warning_trip_select = warning_trip_reg;

   // sticky flags: a set in the same cycle as an ack wins
   always @*
   begin
      undervolt_detect_flag_next = undervolt_detect_flag_reg;
      if (wr_one && reg_wdata[`PMSC_B_UV_ACK])
         undervolt_detect_flag_next = 1'b0;
      if (detector_active && det_s)
         undervolt_detect_flag_next = 1'b1;
      if (!undervolt_detector_on)
         undervolt_detect_flag_next = 1'b0;

      full_powerdown_flag_next = full_powerdown_flag_reg;
      partial_powerdown_flag_next = partial_powerdown_flag_reg;
      if (wr_two && reg_wdata[`PMSC_B_PD_ACK])
      begin
         full_powerdown_flag_next = 1'b0;
         partial_powerdown_flag_next = 1'b0;
      end
      if (stop1_recovered)
         full_powerdown_flag_next = 1'b1;
      if (stop2_recovered)
         partial_powerdown_flag_next = 1'b1;

      undervolt_warning_flag_next = undervolt_warning_flag_reg;
      if (wr_three && reg_wdata[`PMSC_B_WARN_ACK] && !warn_s)
         undervolt_warning_flag_next = 1'b0;
      if (warn_s)
         undervolt_warning_flag_next = 1'b1;
   end

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         undervolt_detect_flag_reg <= 1'b0;
         undervolt_irq_enable_reg <= 1'b0;
         undervolt_stop_enable_reg <= 1'b1;
         bandgap_reg <= 1'b0;
         full_powerdown_flag_reg <= 1'b0;
         partial_powerdown_flag_reg <= 1'b0;
         powerdown_permit_reg <= 1'b0;
         powerdown_mode_select_reg <= 1'b0;
         undervolt_warning_flag_reg <= 1'b0;
      end
      else
      begin
         undervolt_detect_flag_reg <= undervolt_detect_flag_next;
         full_powerdown_flag_reg <= full_powerdown_flag_next;
         partial_powerdown_flag_reg <= partial_powerdown_flag_next;
         undervolt_warning_flag_reg <= undervolt_warning_flag_next;
         if (wr_one)
         begin
            undervolt_irq_enable_reg <= reg_wdata[`PMSC_B_UV_IRQ_EN];
            undervolt_stop_enable_reg <= reg_wdata[`PMSC_B_UV_STOP_EN];
            bandgap_reg <= reg_wdata[`PMSC_B_BG_BUF_ON];
            // bit 1 is reserved; software keeps it zero and it is not stored
         end
         if (wr_two)
         begin
            powerdown_permit_reg <= reg_wdata[`PMSC_B_PD_PERMIT];
            powerdown_mode_select_reg <= reg_wdata[`PMSC_B_PD_MODE];
         end
      end
   end

   // trip selects survive low-voltage and other resets, only power-on clears
   always @(posedge clk)
   begin
      if (!rst_n && por_event)
      begin
         detect_trip_reg <= 1'b0;
         warning_trip_reg <= 1'b0;
      end
      else if (rst_n && wr_three)
      begin
         detect_trip_reg <= reg_wdata[`PMSC_B_DET_TRIP];
         warning_trip_reg <= reg_wdata[`PMSC_B_WARN_TRIP];
      end
   end

   // ack bits and reserved bits read as zero
   always @*
   begin
      rdata_next = 8'h00;
      case (reg_addr)
         `PMSC_OFS_ONE:
         begin
            rdata_next[`PMSC_B_UV_FLAG] = undervolt_detect_flag_reg;
            rdata_next[`PMSC_B_UV_IRQ_EN] = undervolt_irq_enable_reg;
            rdata_next[`PMSC_B_UV_RST_EN] = undervolt_reset_enable;
            rdata_next[`PMSC_B_UV_STOP_EN] = undervolt_stop_enable_reg;
            rdata_next[`PMSC_B_UV_DET_ON] = undervolt_detector_on;
            rdata_next[`PMSC_B_BG_BUF_ON] = bandgap_reg;
         end
         `PMSC_OFS_TWO:
         begin
            rdata_next[`PMSC_B_FULL_PD_FLAG] = full_powerdown_flag_reg;
            rdata_next[`PMSC_B_PART_PD_FLAG] = partial_powerdown_flag_reg;
            rdata_next[`PMSC_B_PD_PERMIT] = powerdown_permit_reg;
            rdata_next[`PMSC_B_PD_MODE] = powerdown_mode_select_reg;
         end
         `PMSC_OFS_THREE:
         begin
            rdata_next[`PMSC_B_WARN_FLAG] = undervolt_warning_flag_reg;
            rdata_next[`PMSC_B_DET_TRIP] = detect_trip_reg;
            rdata_next[`PMSC_B_WARN_TRIP] = warning_trip_reg;
         end
         default:
            rdata_next = 8'h00;
      endcase
   end

   always @(posedge clk)
   begin
      if (!rst_n)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= rdata_next;
      else
         reg_rdata <= 8'h00;
   end

   // lv_reset_event is accepted for symmetry; trip bits keep value on it
   wire unused_lv = lv_reset_event;
endmodule // pmsc_top

// >>> core/pmsc_defines.vh
// Purpose: constants for the power management status and control block
// Assumes: 8-bit registers on a plain strobe port
// Notes: offsets are register indices on the plain port
`ifndef PMSC_DEFINES_VH
`define PMSC_DEFINES_VH
`define PMSC_ADDR_W 2
`define PMSC_OFS_ONE 2'h0
`define PMSC_OFS_TWO 2'h1
`define PMSC_OFS_THREE 2'h2
// power_mgmt_ctrl_one fields
`define PMSC_B_UV_FLAG 7
`define PMSC_B_UV_ACK 6
`define PMSC_B_UV_IRQ_EN 5
`define PMSC_B_UV_RST_EN 4
`define PMSC_B_UV_STOP_EN 3
`define PMSC_B_UV_DET_ON 2
`define PMSC_B_BG_BUF_ON 0
`define PMSC_ONE_RESET 8'h1C
// power_mgmt_ctrl_two fields
`define PMSC_B_FULL_PD_FLAG 4
`define PMSC_B_PART_PD_FLAG 3
`define PMSC_B_PD_ACK 2
`define PMSC_B_PD_PERMIT 1
`define PMSC_B_PD_MODE 0
`define PMSC_TWO_RESET 8'h00
// power_mgmt_ctrl_three fields
`define PMSC_B_WARN_FLAG 7
`define PMSC_B_WARN_ACK 6
`define PMSC_B_DET_TRIP 5
`define PMSC_B_WARN_TRIP 4
`define PMSC_THREE_RESET 8'h00
`endif

// >>> core/pmsc_sync.v
// Purpose: two flip-flop level synchroniser, one per bit
// Assumes: inputs are asynchronous levels
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module pmsc_sync #(
   parameter WIDTH = 4
) (
   input wire clk, // bus clock
   input wire rst_n, // synchronous reset, active low
   input wire [WIDTH-1:0] async_in, // asynchronous levels
   output reg [WIDTH-1:0] sync_out // synchronised levels
);
   reg [WIDTH-1:0] meta_reg;
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta_reg <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule // pmsc_sync

// >>> core/pmsc_wonce.v
// Purpose: write-once storage bits
// Assumes: reset returns the bits to their reset value and rearms them
// Notes: the first write locks all bits of the group together
`timescale 1ns/1ps
module pmsc_wonce #(
   parameter WIDTH = 2,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
   input wire clk, // bus clock
   input wire rst_n, // synchronous reset, active low
   input wire wr_en, // write to the holding register
   input wire [WIDTH-1:0] wr_data, // bits written
   output reg [WIDTH-1:0] value, // stored bits
   output reg locked // high after the first write
);
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         value <= RESET_VAL;
         locked <= 1'b0;
      end
      else if (wr_en && !locked)
      begin
         value <= wr_data;
         locked <= 1'b1;
      end
   end
endmodule // pmsc_wonce

// >>> tb/pmsc_asserts.sv
// Purpose: port checks for the power management registers
// Assumes: one clock, reset synchronous active low
// Notes: detect flag is seen only through irq and reset request
`timescale 1ns/1ps
module pmsc_asserts (
   input wire logic clk, // clock
   input wire logic rst_n, // reset
   input wire logic [1:0] reg_addr, // index
   input wire logic [7:0] reg_wdata, // wdata
   input wire logic reg_wr, // write
   input wire logic reg_rd, // read
   input wire logic [7:0] reg_rdata, // rdata
   input wire logic undervolt_detect_in, // detector
   input wire logic stop_active, // stop
   input wire logic undervolt_irq, // irq
   input wire logic undervolt_reset_req, // reset req
   input wire logic detector_active, // det power
   input wire logic bandgap_buffer_on, // bandgap
   input wire logic stop1_allowed, // stop1
   input wire logic stop2_allowed, // stop2
   input wire logic detect_trip_select, // det trip
   input wire logic warning_trip_select // warn trip
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_BGBUF: assert property (reg_wr && reg_addr == 2'h0 |=> bandgap_buffer_on == $past(reg_wdata[0]))
      else $error("bandgap enable differs from written bit");
   AST_TRIP: assert property (reg_wr && reg_addr == 2'h2 |=>
      {detect_trip_select, warning_trip_select} == $past(reg_wdata[5:4])) else $error("trip selects differ");
   AST_PD_OFF: assert property (reg_wr && reg_addr == 2'h1 && !reg_wdata[1] |=> !stop1_allowed && !stop2_allowed)
      else $error("power-down allowed while forbidden");
   AST_PD_SEL: assert property (reg_wr && reg_addr == 2'h1 && reg_wdata[1] |=>
      stop2_allowed == $past(reg_wdata[0]) && stop1_allowed != $past(reg_wdata[0])) else $error("wrong stop mode");
   AST_RD_ACK: assert property ($past(reg_rd) && !$past(reg_addr[0]) |-> !reg_rdata[6])
      else $error("acknowledge bit read back as one");
   AST_IRQ_RISE: assert property ($rose(undervolt_irq) |-> $past(reg_wr) || $past(undervolt_detect_in, 3))
      else $error("irq rose without synchronised cause");
   AST_RST_RISE: assert property ($rose(undervolt_reset_req) |-> $past(reg_wr) || $past(undervolt_detect_in, 3))
      else $error("reset request rose without cause");
   AST_ACK: assert property (reg_wr && reg_addr == 2'h0 && reg_wdata[6] && !undervolt_detect_in
      && !$past(undervolt_detect_in) && !$past(undervolt_detect_in, 2) |=> !undervolt_irq && !undervolt_reset_req)
      else $error("detect flag survived acknowledge");
   AST_DETOFF: assert property (!stop_active && !detector_active |-> !undervolt_irq && !undervolt_reset_req)
      else $error("detect effect while detector off");
endmodule // pmsc_asserts
bind pmsc_top pmsc_asserts u_pmsc_asserts (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .undervolt_detect_in, .stop_active, .undervolt_irq, .undervolt_reset_req, .detector_active, .bandgap_buffer_on,
   .stop1_allowed, .stop2_allowed, .detect_trip_select, .warning_trip_select);

// >>> tb/pmsc_analog_model.sv
// Purpose: detector comparators and stop wake-up source
// Assumes: comparator outputs settle a few ns after the supply moves
// Notes: the delay keeps edges away from the clock, as a real comparator would
`timescale 1ns/1ps
module pmsc_analog_model (
   input wire logic clk, // bus clock
   input wire logic det_lvl, // supply below detect trip
   input wire logic warn_lvl, // supply below warning trip
   input wire logic [1:0] wake_req, // stop2, stop1 wake
   output logic undervolt_detect_in = 1'h0, // detect output
   output logic undervolt_warning_in = 1'h0, // warning output
   output logic stop1_recovered = 1'h0, // stop1 wake pulse
   output logic stop2_recovered = 1'h0 // stop2 wake pulse
);
   always @(det_lvl) undervolt_detect_in <= #3 det_lvl;
   always @(warn_lvl) undervolt_warning_in <= #3 warn_lvl;
   always @(posedge clk) {stop2_recovered, stop1_recovered} <= wake_req;
endmodule // pmsc_analog_model

// >>> tb/pmsc_top_test.sv
// Purpose: register level test of the power management block
// Assumes: plain strobe port, read data one cycle after the strobe
// Notes: lv_reset_event is informational and tied low
`timescale 1ns/1ps
`include "pmsc_defines.vh"
module pmsc_top_test;
   logic clk = 1'h0, rst_n = 1'h0, por_event = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, stop_active = 1'h0;
   logic det_lvl = 1'h0, warn_lvl = 1'h0, det_in, warn_in, rec1, rec2, irq, rst_req, det_act, bg, s1, s2, dtrip, wtrip;
   logic [1:0] reg_addr = 2'h0, wake_req = 2'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata;
   int err_total = 0, tests_run = 0;
   pmsc_analog_model u_pmsc_analog_model (.clk(clk), .det_lvl(det_lvl), .warn_lvl(warn_lvl), .wake_req(wake_req),
      .undervolt_detect_in(det_in), .undervolt_warning_in(warn_in), .stop1_recovered(rec1), .stop2_recovered(rec2));
   pmsc_top u_pmsc_top (.clk(clk), .rst_n(rst_n), .por_event(por_event), .lv_reset_event(1'h0),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .undervolt_detect_in(det_in), .undervolt_warning_in(warn_in), .stop_active(stop_active),
      .stop1_recovered(rec1), .stop2_recovered(rec2), .undervolt_irq(irq), .undervolt_reset_req(rst_req),
      .detector_active(det_act), .bandgap_buffer_on(bg), .stop1_allowed(s1), .stop2_allowed(s2),
      .detect_trip_select(dtrip), .warning_trip_select(wtrip));
   initial
   begin
      forever #5 clk = ~clk;
   end
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // every access leaves one idle edge so no strobe is driven twice in a step
   task wr(input logic [1:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
      @(posedge clk);
   endtask
   task rd(input logic [1:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1 chk(reg_rdata, e);
      @(posedge clk);
   endtask
   task rst(input logic por);
      rst_n <= 1'h0;
      por_event <= por;
      wt(6);
      rst_n <= 1'h1;
      por_event <= 1'h0;
      @(posedge clk);
   endtask
   task wake(input logic [1:0] w);
      wake_req <= w;
      @(posedge clk);
      wake_req <= 2'h0;
      wt(3);
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      wt(3000);
      err_total++;
      $display("ERROR t=%0t watchdog", $time);
      summarize;
   end
   initial
   begin
      rst(1'h1);
      rd(2'h0, `PMSC_ONE_RESET);
      rd(2'h1, `PMSC_TWO_RESET);
      rd(2'h2, `PMSC_THREE_RESET);
      rd(2'h3, 8'h00);
      $display("reset values done");
      wr(2'h0, 8'h21);
      wr(2'h0, 8'h3D);
      rd(2'h0, 8'h29);
      chk(det_act, 8'h00);
      det_lvl <= 1'h1;
      wt(6);
      rd(2'h0, 8'h29);
      chk(bg, 8'h01);
      wr(2'h2, 8'h30);
      chk({dtrip, wtrip}, 8'h03);
      det_lvl <= 1'h0;
      rst(1'h0);
      rd(2'h2, 8'h30);
      $display("write once done");
      wr(2'h0, 8'h3C);
      det_lvl <= 1'h1;
      wt(6);
      rd(2'h0, 8'hBC);
      chk({irq, rst_req}, 8'h03);
      wr(2'h0, 8'h7C);
      rd(2'h0, 8'hBC);
      det_lvl <= 1'h0;
      wt(6);
      wr(2'h0, 8'h7C);
      rd(2'h0, 8'h3C);
      chk({irq, rst_req, bg}, 8'h00);
      stop_active <= 1'h1;
      wr(2'h0, 8'h34);
      chk(det_act, 8'h00);
      wr(2'h0, 8'h3C);
      chk(det_act, 8'h01);
      stop_active <= 1'h0;
      $display("detect done");
      warn_lvl <= 1'h1;
      wt(6);
      rd(2'h2, 8'hB0);
      wr(2'h2, 8'h70);
      rd(2'h2, 8'hB0);
      warn_lvl <= 1'h0;
      wt(6);
      rd(2'h2, 8'hB0);
      wr(2'h2, 8'h70);
      rd(2'h2, 8'h30);
      $display("warning done");
      wake(2'h1);
      rd(2'h1, 8'h10);
      wake(2'h2);
      rd(2'h1, 8'h18);
      wr(2'h1, 8'h07);
      rd(2'h1, 8'h03);
      chk({s2, s1}, 8'h02);
      wr(2'h1, 8'h02);
      chk({s2, s1}, 8'h01);
      wr(2'h1, 8'h00);
      chk({s2, s1}, 8'h00);
      $display("power-down done");
      summarize;
   end
endmodule // pmsc_top_test
